/* design/reset_seq_defines.vh */
// Constants for the reset sequencer: synchroniser depth, sequencing phases.
// Included by the reset sequencer only.
`ifndef RESET_SEQ_DEFINES_VH
`define RESET_SEQ_DEFINES_VH
// Synchroniser stages for the external reset input
`define RST_SYNC_STAGES 2
// Sequencer phase codes
`define PH_RUN 2'h0
`define PH_INACTIVE 2'h1
`define PH_FLOAT 2'h2
// Cycles the control outputs are held inactive before they float
`define INACTIVE_HOLD_CYCLES 4'h1
`endif

/* design/reset_sequencer.v */
// Reset sequencer with pin-float test strap capture.
// Assumes the core clock runs whenever reset is to act; the core supplies
// bus-cycle status and its own control output levels and enables.
// Summary of operation
// - Full reset whenever the external active-low reset input is low.
// - External reset passes a clocked synchroniser before internal use.
// - Reset during operation stops all activity, returns to a known state.
// - A bus cycle in progress at reset is abandoned immediately.
// - Control outputs driven inactive first, then released to high impedance.
// - During reset, lock and four upper address lines become pulled-up inputs.
// - Only the strap line may be pulled low; it requests pin-float mode.
`timescale 1ns/10ps
`default_nettype none
`include "reset_seq_defines.vh"
module reset_sequencer #(
  parameter CTRL_W = 8,
  parameter [CTRL_W-1:0] CTRL_INACTIVE = 8'hFF
) (
  // Clock and board reset
  input wire sys_clk,
  input wire rst_n,
  input wire ext_reset_n,
  // Core side
  input wire bus_cycle_active,
  input wire [CTRL_W-1:0] core_ctrl_out,
  input wire core_ctrl_oe,
  input wire core_lock_out,
  input wire [3:0] core_upper_addr_out,
  output wire core_reset_n,
  output wire bus_abort,
  output reg pin_float_test_mode,
  // Bus control pins
  output reg [CTRL_W-1:0] ctrl_pin_out,
  output reg ctrl_pin_oe,
  // Lock and upper address pins; bit 3 is upper_addr_test_strap
  input wire lock_pin_in,
  output reg lock_pin_out,
  output reg lock_pin_oe,
  output wire lock_pullup_en,
  input wire [3:0] upper_addr_pin_in,
  output reg [3:0] upper_addr_pin_out,
  output reg [3:0] upper_addr_pin_oe,
  output wire upper_addr_pullup_en
);

  reg [`RST_SYNC_STAGES-1:0] sync_r;
  reg [1:0] phase_r;
  reg [1:0] phase_nxt;
  reg [3:0] hold_cnt_r;
  reg in_reset_d_r;
  wire in_reset;
  wire strap_float;

  // synchroniser chain; only the last stage is read
  always @(posedge sys_clk) begin
    if (!rst_n)
      sync_r[0] <= 1'b0;
    else
      sync_r[0] <= ext_reset_n;
  end

  genvar si;
  generate
    for (si = 1; si < `RST_SYNC_STAGES; si = si + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (!rst_n)
          sync_r[si] <= 1'b0;
        else
          sync_r[si] <= sync_r[si-1];
      end
    end
  endgenerate

  // reset asserted from the synchronised input
  assign in_reset = ~sync_r[`RST_SYNC_STAGES-1];
  assign core_reset_n = ~in_reset;

  assign bus_abort = in_reset & bus_cycle_active;

  assign lock_pullup_en = in_reset;
  assign upper_addr_pullup_en = in_reset;

  always @* begin
    phase_nxt = phase_r;
    case (phase_r)
      `PH_RUN: begin
        if (in_reset)
          phase_nxt = `PH_INACTIVE;
      end
      `PH_INACTIVE: begin
        if (!in_reset)
          phase_nxt = `PH_RUN;
        else if (hold_cnt_r >= `INACTIVE_HOLD_CYCLES)
          phase_nxt = `PH_FLOAT;
      end
      `PH_FLOAT: begin
        if (!in_reset)
          phase_nxt = `PH_RUN;
      end
      default: phase_nxt = `PH_FLOAT;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r <= `PH_FLOAT;
      hold_cnt_r <= 4'h0;
      in_reset_d_r <= 1'b1;
      pin_float_test_mode <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      in_reset_d_r <= in_reset;
      if (phase_nxt == `PH_INACTIVE)
        hold_cnt_r <= hold_cnt_r + 4'h1;
      else
        hold_cnt_r <= 4'h0;
      // strap caught at synchronised release, held until next reset
      if (in_reset)
        pin_float_test_mode <= 1'b0;
      else if (in_reset_d_r)
        pin_float_test_mode <= ~upper_addr_pin_in[3];
    end
  end

  // pins stay floating on the release edge, before the mode flop catches up
  assign strap_float = pin_float_test_mode | (in_reset_d_r & ~in_reset & ~upper_addr_pin_in[3]);

  // Enable of a pin for the phase being entered
  function drive_en;
    input [1:0] phase;
    input run_want;
    input hold_want;
    input float_req;
    begin
      case (phase)
        `PH_RUN: begin
          drive_en = run_want & ~float_req;
        end
        `PH_INACTIVE: begin
          drive_en = hold_want;
        end
        default: begin
          drive_en = 1'b0;
        end
      endcase
    end
  endfunction

  // Level of a pin: core value while running, idle level otherwise
  function out_level;
    input [1:0] phase;
    input core_val;
    input idle_val;
    begin
      if (phase == `PH_RUN)
        out_level = core_val;
      else
        out_level = idle_val;
    end
  endfunction

  // control group: inactive drive, then float
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_pin_oe <= 1'b0;
    end else begin
      ctrl_pin_oe <= drive_en(phase_nxt, core_ctrl_oe, 1'b1, strap_float);
    end
  end

  // control levels, one flop per pin
  genvar gi;
  generate
    for (gi = 0; gi < CTRL_W; gi = gi + 1) begin : g_ctrl
      always @(posedge sys_clk) begin
        if (!rst_n)
          ctrl_pin_out[gi] <= CTRL_INACTIVE[gi];
        else
          ctrl_pin_out[gi] <= out_level(phase_nxt, core_ctrl_out[gi], CTRL_INACTIVE[gi]);
      end
    end
  endgenerate

  // lock becomes an input as soon as reset is seen
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_pin_out <= 1'b1;
      lock_pin_oe <= 1'b0;
    end else begin
      lock_pin_out <= out_level(phase_nxt, core_lock_out, 1'b1);
      lock_pin_oe <= drive_en(phase_nxt, 1'b1, 1'b0, strap_float);
    end
  end

  // upper address lines, strap line included, become inputs during reset
  genvar ai;
  generate
    for (ai = 0; ai < 4; ai = ai + 1) begin : g_addr
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          upper_addr_pin_out[ai] <= 1'b1;
          upper_addr_pin_oe[ai] <= 1'b0;
        end else begin
          upper_addr_pin_out[ai] <= out_level(phase_nxt, core_upper_addr_out[ai], 1'b1);
          upper_addr_pin_oe[ai] <= drive_en(phase_nxt, 1'b1, 1'b0, strap_float);
        end
      end
    end
  endgenerate

endmodule // reset_sequencer
`default_nettype wire

/* tb/reset_seq_sva.sv */
// Port checker for the reset sequencer.
// Bound to the design from the bench top.
`timescale 1ns/10ps
`default_nettype none
module reset_seq_sva #(parameter CTRL_W = 8, parameter [CTRL_W-1:0] CTRL_INACTIVE = 8'hFF) (
  // Clock, reset and inputs
  input wire logic sys_clk, rst_n, ext_reset_n, bus_cycle_active,
  input wire logic [3:0] upper_addr_pin_in,
  // Outputs
  input wire logic core_reset_n, bus_abort, pin_float_test_mode, ctrl_pin_oe, lock_pin_oe,
  input wire logic [CTRL_W-1:0] ctrl_pin_out,
  input wire logic lock_pullup_en, upper_addr_pullup_en,
  input wire logic [3:0] upper_addr_pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_sync; $fell(ext_reset_n) |-> ##2 !core_reset_n; endproperty
  a_sync: assert property (p_sync) else $error("reset entry late");
  property p_rel; $rose(ext_reset_n) |-> ##2 core_reset_n; endproperty
  a_rel: assert property (p_rel) else $error("reset exit late");
  property p_abort; bus_abort == (!core_reset_n && bus_cycle_active); endproperty
  a_abort: assert property (p_abort) else $error("abort wrong");
  property p_pull; lock_pullup_en == !core_reset_n && upper_addr_pullup_en == !core_reset_n;
  endproperty
  a_pull: assert property (p_pull) else $error("pullups wrong");
  property p_inact; $fell(core_reset_n) && !pin_float_test_mode |->
    ##1 (ctrl_pin_oe && ctrl_pin_out == CTRL_INACTIVE) ##1 !ctrl_pin_oe; endproperty
  a_inact: assert property (p_inact) else $error("no inactive drive");
  property p_strap; $rose(core_reset_n) |=> pin_float_test_mode == !$past(upper_addr_pin_in[3]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not taken");
  property p_hold; core_reset_n && $past(core_reset_n, 2) |-> $stable(pin_float_test_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed");
  property p_float; pin_float_test_mode && core_reset_n |->
    !ctrl_pin_oe && !lock_pin_oe && upper_addr_pin_oe == 4'h0; endproperty
  a_float: assert property (p_float) else $error("pins driven in test mode");
endmodule // reset_seq_sva
`default_nettype wire

/* tb/board_model.sv */
// Board reset source and test strap driver.
// Reset is low from power-on; the strap outlasts the reset release.
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input wire logic sys_clk,
  input wire logic hold_rst,
  input wire logic want_test,
  output var logic ext_reset_n,
  output logic [3:0] upper_addr_pin_in,
  output logic lock_pin_in
);
  logic [7:0] tail_r;
  initial ext_reset_n = 1'b0;
  initial tail_r = 8'hFF;
  assign lock_pin_in = 1'b1;
  // strap only, low before and after the release
  assign upper_addr_pin_in = {~(want_test & (hold_rst | (|tail_r))), 3'h7};
  always @(posedge sys_clk) begin
    tail_r <= {tail_r[6:0], hold_rst};
    ext_reset_n <= ~(hold_rst | tail_r[0]);
  end
endmodule // board_model
`default_nettype wire

/* tb/reset_sequencer_tb.sv */
// Bench for the reset sequencer.
// Board model on the reset side; core side held at fixed levels except bus_cycle_active, raised during warm resets.
`timescale 1ns/10ps
`default_nettype none
module reset_sequencer_tb;
  logic sys_clk = 0, rst_n = 0, hold_rst = 1, want_test = 0, busy = 0;
  wire ext_reset_n, lock_pin_in, core_reset_n, bus_abort, pin_float_test_mode, ctrl_pin_oe;
  wire lock_pullup_en, upper_addr_pullup_en, lock_pin_out, lock_pin_oe;
  wire [3:0] upper_addr_pin_in, upper_addr_pin_out, upper_addr_pin_oe;
  wire [7:0] ctrl_pin_out;
  int num_errors = 0, n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  board_model u_board_model (.sys_clk(sys_clk), .hold_rst(hold_rst), .want_test(want_test),
    .ext_reset_n(ext_reset_n), .upper_addr_pin_in(upper_addr_pin_in), .lock_pin_in(lock_pin_in));
  reset_sequencer u_reset_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .bus_cycle_active(busy), .core_ctrl_out(8'h5A), .core_ctrl_oe(1'b1), .core_lock_out(1'b0),
    .core_upper_addr_out(4'h3), .core_reset_n(core_reset_n), .bus_abort(bus_abort),
    .pin_float_test_mode(pin_float_test_mode), .ctrl_pin_out(ctrl_pin_out),
    .ctrl_pin_oe(ctrl_pin_oe), .lock_pin_in(lock_pin_in), .lock_pin_out(lock_pin_out),
    .lock_pin_oe(lock_pin_oe), .lock_pullup_en(lock_pullup_en),
    .upper_addr_pin_in(upper_addr_pin_in), .upper_addr_pin_out(upper_addr_pin_out),
    .upper_addr_pin_oe(upper_addr_pin_oe), .upper_addr_pullup_en(upper_addr_pullup_en));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task t_release(input logic t);
    @(posedge sys_clk);
    want_test <= t;
    hold_rst <= 1'b0;
    cyc(14);
    chk("mode", 8'(t), 8'(pin_float_test_mode));
    chk("ctrl_oe", 8'(!t), 8'(ctrl_pin_oe));
    chk("lock_oe", 8'(!t), 8'(lock_pin_oe));
    chk("addr_oe", t ? 8'h00 : 8'h0F, 8'(upper_addr_pin_oe));
  endtask
  task t_warm;
    @(posedge sys_clk);
    busy <= 1'b1;
    hold_rst <= 1'b1;
    cyc(7);
    chk("abort", 8'h01, 8'(bus_abort));
    chk("ctrl_oe", 8'h00, 8'(ctrl_pin_oe));
    chk("pullup", 8'h01, 8'(lock_pullup_en & upper_addr_pullup_en));
    chk("lock_oe", 8'h00, 8'(lock_pin_oe));
    chk("lock_out", 8'h01, 8'(lock_pin_out));
    chk("addr_oe", 8'h00, 8'(upper_addr_pin_oe));
    chk("addr_out", 8'h0F, 8'(upper_addr_pin_out));
    @(posedge sys_clk);
    busy <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_release(1'b0);
    chk("ctrl", 8'h5A, ctrl_pin_out);
    chk("lock_out", 8'h00, 8'(lock_pin_out));
    chk("addr_out", 8'h03, 8'(upper_addr_pin_out));
    t_warm;
    t_release(1'b1);
    t_warm;
    t_release(1'b0);
    results;
  end
  initial begin
    #20000;
    num_errors++;
    results;
  end
  task results;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule // reset_sequencer_tb
bind reset_sequencer reset_seq_sva #(.CTRL_W(CTRL_W), .CTRL_INACTIVE(CTRL_INACTIVE)) u_sva (.*);
`default_nettype wire
